/* rtl/serial_flash_cmd.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1 - Finished erase leaves every byte all ones.
// RL2 - Erase dropped when any region is protected.
// RL3 - Writes need the write latch set first.
// RL4 - Erase is one opcode, two values, nothing after.
// RL5 - Erase starts at chip select rise.
// RL6 - Busy stays set until erase finishes.
// RL7 - Status read accepted at any time.
// RL8 - Status repeats every eight clocks up to clock 63, then bit 0 holds until deselect.
// RL9 - Host checks busy before new commands.
// RL10 - Latch set command sets the write latch.
// RL11 - Latch set acts at chip select rise.
// RL12 - Latch clear drops latch and auto-increment mode.
// RL13 - Latch clear acts at chip select rise.
// RL14 - Arm is lost unless status write follows.
// RL15 - Arm acts at chip select rise.
// RL16 - Status write changes protect and lock bits.
// RL17 - Status write applies at chip select rise.
// RL18 - Locked and pin low: status write ignored.
// RL19 - Pin low: lock bit only goes up.
// RL20 - Pin high: lock and levels freely writable.
// RL21 - Lock decision uses values before select rise.
// RL22 - One write sets lock and levels together.
// RL23 - Status holds a pollable busy flag.
// RL24 - Auto-increment mode limits accepted commands.
// RL25 - Opcodes and bit positions are named constants.
// RL26 - Sample on rising, shift out on falling.
// RL27 - Completed write clears the write latch.
// RL28 - Protected test derives from protect levels.
module serial_flash_cmd
	import serial_flash_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYCLES_DFLT
) (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	input  wire logic       i_si,
	input  wire logic       i_wp_n,
	input  wire logic       i_ext_busy,
	input  wire logic       i_ext_write_done,
	input  wire logic       i_aai_enter,
	output logic            o_so,
	output logic            o_so_oe_n,
	output logic            o_erase_active,
	output logic [7:0]      o_erase_fill,
	output logic            o_erase_done,
	output logic            o_any_protected,
	output logic            o_write_latch,
	output logic [7:0]      o_status
);

	// Link domain state, clocked by the serial clock.
	logic             frame_fresh;
	logic [5:0]       bit_count;
	logic [7:0]       shift;
	logic [7:0]       opcode;
	logic [7:0]       data_byte;
	logic             frame_tog;
	logic             read_mode;
	logic [7:0]       status_meta;
	logic [7:0]       status_sync;
	logic [7:0]       next_opcode;

	// System domain state.
	logic             cs_meta;
	logic             cs_sync;
	logic             cs_prev;
	logic             tog_meta;
	logic             tog_sync;
	logic             tog_seen;
	logic             wp_meta;
	logic             wp_sync;
	logic             exec;
	logic             erasing;
	logic [31:0]      erase_left;
	erase_state_t     erase_state;
	logic             write_latch_bit;
	logic             auto_increment_mode_bit;
	logic             armed;
	logic [2:0]       protect_level;
	logic             protect_lock;
	logic             busy;
	logic             is_erase_op;

	function automatic logic op_is(input logic [7:0] op, input logic [5:0] cnt,
		input logic [7:0] want, input logic [5:0] len);
		op_is = (op == want) && (cnt == len);
	endfunction : op_is

	// The byte completing on this edge, used before the opcode register updates.
	assign next_opcode = {shift[6:0], i_si};

	// Set while chip select is high; the first clock of a frame clears it.
	always_ff @(posedge i_sck or posedge i_cs_n or posedge i_sys_rst) begin
		if (i_sys_rst || i_cs_n) begin
			frame_fresh <= 1'b1;
		end else begin
			frame_fresh <= 1'b0;
		end
	end

	// RL26 rising edge sampling.
	// Counters are not cleared by deselect so the system side can read them afterwards.
	always_ff @(posedge i_sck or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bit_count <= 6'h00;
			shift     <= 8'h00;
			frame_tog <= 1'b0;
		end else if (frame_fresh) begin
			bit_count <= 6'h01;
			shift     <= {7'h00, i_si};
			frame_tog <= ~frame_tog;
		end else begin
			shift <= next_opcode;
			if (bit_count != BIT_COUNT_MAX) begin
				bit_count <= bit_count + 6'h01;
			end
		end
	end

	// Opcode and data bytes latch on their last bit.
	always_ff @(posedge i_sck or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			opcode    <= 8'h00;
			data_byte <= 8'h00;
		end else if (!frame_fresh && bit_count == BITS_LAST_OP) begin
			opcode <= next_opcode;
		end else if (!frame_fresh && bit_count == BITS_LAST_DATA) begin
			data_byte <= next_opcode;
		end
	end

	// RL7 read always decoded.
	// Status read needs no latch and ignores busy, so it works mid-erase.
	always_ff @(posedge i_sck or posedge i_cs_n or posedge i_sys_rst) begin
		if (i_sys_rst || i_cs_n) begin
			read_mode <= 1'b0;
		end else if (!frame_fresh && bit_count == BITS_LAST_OP) begin
			read_mode <= (next_opcode == OP_STATUS_READ);
		end
	end

	// Each status bit is an independent level, so a per-bit pair of flops is enough.
	// The serial clock stops between frames; the opcode's eight clocks flush the pair.
	always_ff @(posedge i_sck or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			status_meta <= 8'h00;
			status_sync <= 8'h00;
		end else begin
			status_meta <= o_status;
			status_sync <= status_meta;
		end
	end

	// RL8 repeating status output.
	// RL26 falling edge shifting.
	always_ff @(negedge i_sck or posedge i_cs_n or posedge i_sys_rst) begin
		if (i_sys_rst || i_cs_n) begin
			o_so      <= 1'b0;
			o_so_oe_n <= 1'b1;
		end else if (read_mode) begin
			o_so      <= status_sync[3'h7 - bit_count[2:0]];
			o_so_oe_n <= 1'b0;
		end
	end

	// Pins from outside the system clock domain pass two flops.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			wp_meta  <= 1'b0;
			wp_sync  <= 1'b0;
		end else begin
			cs_meta  <= i_cs_n;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
			tog_meta <= frame_tog;
			tog_sync <= tog_meta;
			wp_meta  <= i_wp_n;
			wp_sync  <= wp_meta;
		end
	end

	// RL5 act on select rise.
	// Opcode, data and count are still while chip select is high, so reading them
	// across the boundary after the synchronised rise is safe; a frame with no
	// clocks leaves the toggle alone and is not run twice.
	assign exec = cs_sync && !cs_prev && (tog_sync != tog_seen);
	assign busy = erasing || i_ext_busy;
	// RL4 two erase opcodes.
	assign is_erase_op = op_is(opcode, bit_count, OP_ERASE_A, BITS_OPCODE)
		|| op_is(opcode, bit_count, OP_ERASE_B, BITS_OPCODE);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tog_seen <= 1'b0;
		end else if (exec) begin
			tog_seen <= tog_sync;
		end
	end

	// RL6 erase timer.
	// RL2 protected erase dropped.
	// RL3 erase needs latch.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			erase_state  <= ST_IDLE;
			erasing      <= 1'b0;
			erase_left   <= 32'h0000_0000;
			o_erase_done <= 1'b0;
		end else begin
			o_erase_done <= 1'b0;
			case (erase_state)
				ST_IDLE: begin
					if (exec && is_erase_op && write_latch_bit && !auto_increment_mode_bit && !busy
						&& protect_level == PROTECT_RESET) begin
						erase_state <= ST_ERASE;
						erasing     <= 1'b1;
						erase_left  <= 32'(ERASE_CYCLES - 1);
					end
				end
				ST_ERASE: begin
					if (erase_left == 32'h0000_0000) begin
						erase_state  <= ST_IDLE;
						erasing      <= 1'b0;
						o_erase_done <= 1'b1;
					end else begin
						erase_left <= erase_left - 32'h0000_0001;
					end
				end
				default: begin
					erase_state <= ST_IDLE;
					erasing     <= 1'b0;
				end
			endcase
		end
	end

	// RL1 erased pattern.
	// The array fills with ones for as long as the erase runs.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_erase_active <= 1'b0;
			o_erase_fill   <= ERASED_BYTE;
		end else begin
			o_erase_active <= erasing;
			o_erase_fill   <= ERASED_BYTE;
		end
	end

	// Write latch: clears come first so a set in the same cycle wins.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			write_latch_bit <= 1'b0;
		end else begin
			// RL27 latch auto clear.
			if (i_ext_write_done || o_erase_done) begin
				write_latch_bit <= 1'b0;
			end
			if (exec && !busy && !auto_increment_mode_bit && op_is(opcode, bit_count, OP_STATUS_WRITE, BITS_OP_DATA)
				&& (write_latch_bit || armed) && !(!wp_sync && protect_lock)) begin
				write_latch_bit <= 1'b0;
			end
			// RL12 latch clear.
			// RL13 clear at select rise.
			if (exec && op_is(opcode, bit_count, OP_LATCH_CLEAR, BITS_OPCODE)) begin
				write_latch_bit <= 1'b0;
			end
			// RL10 latch set.
			// RL11 set at select rise.
			if (exec && !busy && !auto_increment_mode_bit && op_is(opcode, bit_count, OP_LATCH_SET, BITS_OPCODE)) begin
				write_latch_bit <= 1'b1;
			end
		end
	end

	// RL24 auto-increment mode.
	// Entry comes from the word program logic; only latch clear leaves it here.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			auto_increment_mode_bit <= 1'b0;
		end else if (i_aai_enter) begin
			auto_increment_mode_bit <= 1'b1;
		end else if (exec && op_is(opcode, bit_count, OP_LATCH_CLEAR, BITS_OPCODE)) begin
			auto_increment_mode_bit <= 1'b0;
		end
	end

	// RL14 arm lasts one command.
	// RL15 arm at select rise.
	// Any other clocked frame, status read included, wastes the arm.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			armed <= 1'b0;
		end else if (exec) begin
			armed <= !busy && !auto_increment_mode_bit && op_is(opcode, bit_count, OP_STATUS_ARM, BITS_OPCODE);
		end
	end

	// RL16 protect and lock only.
	// RL17 apply at select rise.
	// RL18 locked write ignored.
	// RL21 pre-rise pin and lock.
	// A write is refused while locked with the pin low, so any accepted write
	// can only move the lock from zero to one in that case.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			protect_level <= PROTECT_RESET;
			protect_lock  <= 1'b0;
		end else if (exec && !busy && !auto_increment_mode_bit && (write_latch_bit || armed)
			&& op_is(opcode, bit_count, OP_STATUS_WRITE, BITS_OP_DATA)
			&& !(!wp_sync && protect_lock)) begin
			// RL20 pin high free write.
			// RL22 lock and levels together.
			protect_level <= {data_byte[BP2_POS], data_byte[BP1_POS], data_byte[BP0_POS]};
			// RL19 lock only rises.
			protect_lock  <= data_byte[BPL_POS] | (protect_lock & ~wp_sync);
		end
	end

	// RL23 busy in status.
	// RL25 named bit positions.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_status <= 8'h00;
		end else begin
			o_status           <= 8'h00;
			o_status[BUSY_POS] <= busy;
			o_status[WEL_POS]  <= write_latch_bit;
			o_status[BP0_POS]  <= protect_level[0];
			o_status[BP1_POS]  <= protect_level[1];
			o_status[BP2_POS]  <= protect_level[2];
			o_status[AAI_POS]  <= auto_increment_mode_bit;
			o_status[BPL_POS]  <= protect_lock;
		end
	end

	// RL28 protected region test.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_any_protected <= 1'b0;
			o_write_latch   <= 1'b0;
		end else begin
			o_any_protected <= (protect_level != PROTECT_RESET);
			o_write_latch   <= write_latch_bit;
		end
	end

endmodule : serial_flash_cmd

`default_nettype wire

/* rtl/serial_flash_pkg.sv */
package serial_flash_pkg;

	// Opcodes; the two erase values are fixed, the others are design choices.
	localparam logic [7:0] OP_ERASE_A      = 8'h60;
	localparam logic [7:0] OP_ERASE_B      = 8'hc7;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_LATCH_SET    = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] OP_STATUS_ARM   = 8'h50;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

	// Status register bit positions.
	localparam int BUSY_POS = 0;
	localparam int WEL_POS  = 1;
	localparam int BP0_POS  = 2;
	localparam int BP1_POS  = 3;
	localparam int BP2_POS  = 4;
	localparam int AAI_POS  = 6;
	localparam int BPL_POS  = 7;

	// Serial frame lengths, last-bit counts and the count ceiling, in bits.
	localparam logic [5:0] BITS_OPCODE    = 6'h08;
	localparam logic [5:0] BITS_OP_DATA   = 6'h10;
	localparam logic [5:0] BITS_LAST_OP   = 6'h07;
	localparam logic [5:0] BITS_LAST_DATA = 6'h0f;
	localparam logic [5:0] BIT_COUNT_MAX  = 6'h3f;

	// Values after reset and the erased byte pattern.
	localparam logic [2:0] PROTECT_RESET = 3'h0;
	localparam logic [7:0] ERASED_BYTE   = 8'hff;

	// Whole-array erase time and its cycle count at the system clock.
	localparam int ERASE_TIME_MS      = 4;
	localparam int CLK_KHZ            = 125000;
	localparam int ERASE_CYCLES_DFLT  = ERASE_TIME_MS * CLK_KHZ;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_ERASE = 1'b1
	} erase_state_t;

endpackage : serial_flash_pkg

/* testbench/serial_flash_cmd_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_bench
	import serial_flash_pkg::*;
;
	logic       i_clk, i_sys_rst, i_wp_n, i_ext_busy, i_ext_write_done, i_aai_enter;
	wire logic  sck, cs_n, si, so, so_oe_n, act, done, prot, latch, so_line;
	wire logic [7:0] fill, status;
	int         error_cnt, samples_checked;
	logic [15:0] rd;
	// No pull on the output line, so a released line reads inverted.
	assign so_line = so_oe_n ? ~so : so;
	serial_flash_cmd #(.ERASE_CYCLES(200)) u_serial_flash_cmd (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n),
		.i_ext_busy(i_ext_busy), .i_ext_write_done(i_ext_write_done),
		.i_aai_enter(i_aai_enter), .o_so(so), .o_so_oe_n(so_oe_n), .o_erase_active(act),
		.o_erase_fill(fill), .o_erase_done(done), .o_any_protected(prot),
		.o_write_latch(latch), .o_status(status));
	spi_host_model u_spi_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic cmd(input logic [7:0] op);
		u_spi_host_model.frame({16'h0000, op}, 8, rd);
	endtask : cmd
	task automatic status_read_cmd(input logic [7:0] exp);
		u_spi_host_model.frame({OP_STATUS_READ, 16'h0000}, 24, rd);
		check("status read", rd[15:8], exp);
		check("status repeat", rd[7:0], exp);
	endtask : status_read_cmd
	task automatic swrite(input logic [7:0] v);
		cmd(OP_STATUS_ARM);
		u_spi_host_model.frame({8'h00, OP_STATUS_WRITE, v}, 16, rd);
	endtask : swrite
	task automatic settle();
		repeat (8) @(posedge i_clk);
	endtask : settle
	task automatic t_latch();
		cmd(OP_LATCH_SET);
		check("latch port", {7'h0, latch}, 8'h01);
		status_read_cmd(8'h02);
		cmd(OP_LATCH_CLEAR);
		check("status", status, 8'h00);
		u_spi_host_model.frame(24'h000003, 7, rd);
		check("short frame", status, 8'h00);
		@(posedge i_clk) i_aai_enter <= 1'b1;
		@(posedge i_clk) i_aai_enter <= 1'b0;
		settle();
		cmd(OP_LATCH_SET);
		check("auto mode", status, 8'h40);
		cmd(OP_LATCH_CLEAR);
		check("auto cleared", status, 8'h00);
		cmd(OP_LATCH_SET);
		@(posedge i_clk) i_ext_write_done <= 1'b1;
		@(posedge i_clk) i_ext_write_done <= 1'b0;
		settle();
		check("write done", status, 8'h00);
		@(posedge i_clk) i_ext_busy <= 1'b1;
		settle();
		status_read_cmd(8'h01);
		cmd(OP_LATCH_SET);
		check("set while busy", status, 8'h01);
		@(posedge i_clk) i_ext_busy <= 1'b0;
		settle();
		$display("test latch done");
	endtask : t_latch
	task automatic t_swrite();
		u_spi_host_model.frame({8'h00, OP_STATUS_WRITE, 8'h9c}, 16, rd);
		check("unarmed write", status, 8'h00);
		cmd(OP_STATUS_ARM);
		status_read_cmd(8'h00);
		u_spi_host_model.frame({8'h00, OP_STATUS_WRITE, 8'h9c}, 16, rd);
		check("arm lost", status, 8'h00);
		swrite(8'hff);
		check("write all", status, 8'h9c);
		@(posedge i_clk) i_wp_n <= 1'b0;
		settle();
		swrite(8'h00);
		check("locked", status, 8'h9c);
		@(posedge i_clk) i_wp_n <= 1'b1;
		settle();
		swrite(8'h00);
		check("pin high", status, 8'h00);
		@(posedge i_clk) i_wp_n <= 1'b0;
		settle();
		swrite(8'h80);
		check("lock up", status, 8'h80);
		@(posedge i_clk) i_wp_n <= 1'b1;
		settle();
		swrite(8'h04);
		check("level write", status, 8'h04);
		$display("test status write done");
	endtask : t_swrite
	task automatic t_erase(input logic [7:0] op);
		cmd(OP_LATCH_SET);
		cmd(op);
		check("erase busy", status, 8'h03);
		status_read_cmd(8'h03);
		// wait for the erase done pulse before the next command.
		for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge i_clk);
		check("erase done", {7'h0, done}, 8'h01);
		check("fill", fill, ERASED_BYTE);
		settle();
		check("after erase", status, 8'h00);
		$display("test erase done");
	endtask : t_erase
	// System clock starts low and toggles every 4 ns.
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Watchdog that cuts a hang short.
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	// Main sequence.
	initial begin
		{i_ext_busy, i_ext_write_done, i_aai_enter} <= 3'h0;
		i_wp_n <= 1'b1;
		i_sys_rst <= 1'b1;
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		settle();
		check("reset", status, 8'h00);
		check("oe idle", {7'h0, so_oe_n}, 8'h01);
		t_latch();
		t_swrite();
		cmd(OP_LATCH_SET);
		cmd(OP_ERASE_A);
		check("protected", status, 8'h06);
		swrite(8'h00);
		cmd(OP_ERASE_A);
		check("no latch", status, 8'h00);
		cmd(OP_LATCH_SET);
		u_spi_host_model.frame({8'h00, OP_ERASE_A, 8'h00}, 16, rd);
		check("long erase", status, 8'h02);
		cmd(OP_LATCH_CLEAR);
		t_erase(OP_ERASE_A);
		t_erase(OP_ERASE_B);
		report_and_stop();
	end
endmodule : serial_flash_cmd_bench
`default_nettype wire

/* testbench/serial_flash_cmd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_monitor
	import serial_flash_pkg::*;
#(
	parameter int ERASE_CYCLES = 200
) (
	input wire logic       i_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_cs_n,
	input wire logic       i_wp_n,
	input wire logic       i_ext_busy,
	input wire logic       o_so_oe_n,
	input wire logic       o_erase_active,
	input wire logic [7:0] o_erase_fill,
	input wire logic       o_erase_done,
	input wire logic       o_any_protected,
	input wire logic       o_write_latch,
	input wire logic [7:0] o_status
);
	logic [31:0] run;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Erase length is judged at its end, since the count is far too long to unroll.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			run <= '0;
		else if (o_erase_active)
			run <= run + 32'h1;
		else
			run <= '0;
	end
	chk_oe_idle: assert property (i_cs_n |-> o_so_oe_n)
		else $error("output driven while deselected");
	chk_fill_ones: assert property (o_erase_fill == ERASED_BYTE)
		else $error("erase fill not all ones");
	chk_done_pulse: assert property (o_erase_done |=> !o_erase_done)
		else $error("erase done longer than one cycle");
	chk_erase_len: assert property (o_erase_done |->
		run >= ERASE_CYCLES - 4 && run <= ERASE_CYCLES + 2)
		else $error("erase length wrong");
	chk_done_clears: assert property (o_erase_done |->
		##[0:2] (!o_status[BUSY_POS] && !o_status[WEL_POS]))
		else $error("busy or latch left after erase");
	chk_erase_guard: assert property ($rose(o_erase_active) |-> !o_any_protected)
		else $error("erase started on protected array");
	chk_busy_flag: assert property (o_status[BUSY_POS] && !i_ext_busy
		&& !$past(i_ext_busy, 3) |-> ##[0:1] o_erase_active)
		else $error("busy without erase");
	chk_latch_copy: assert property ($rose(o_status[WEL_POS]) |=> o_write_latch)
		else $error("latch port lags status");
	chk_protect_flag: assert property ((|o_status[BP2_POS:BP0_POS])
		|-> ##[0:1] o_any_protected)
		else $error("protected flag missing");
	chk_lock_hold: assert property (o_status[BPL_POS] && !i_wp_n
		&& $past(!i_wp_n, 4) |=> o_status[BPL_POS]
		&& $stable(o_status[BP2_POS:BP0_POS]))
		else $error("locked status changed");
	cover property (o_erase_done);
	cover property ($rose(o_status[BPL_POS]));
	cover property (!o_so_oe_n);
endmodule : serial_flash_cmd_monitor
bind serial_flash_cmd serial_flash_cmd_monitor #(.ERASE_CYCLES(ERASE_CYCLES))
	u_serial_flash_cmd_monitor (.*);
`default_nettype wire

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so
);
	logic [15:0] rx;
	// The link clock idles low and only runs inside a frame.
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// whole frame: select low over every bit, raised after.
	task automatic frame(input logic [23:0] d, input int n, output logic [15:0] rd);
		o_cs_n <= 1'b0;
		#10;
		for (int i = 0; i < n; i++) begin
			o_si <= d[n-1-i];
			#7.5 o_sck <= 1'b1;
			#0.1 if (i > 7) rx = {rx[14:0], i_so};
			#7.4 o_sck <= 1'b0;
		end
		// A released input shows the inverse of its last bit, never a stale value.
		#5 o_si <= ~o_si;
		o_cs_n <= 1'b1;
		rd = rx;
		#200;
	endtask : frame
endmodule : spi_host_model
`default_nettype wire
